// file: rtl/lta_pkg.sv
/*
 * Constants for the line test and alarm register bank: register offsets,
 * field widths, reset values and port widths.
 * Assumes a single synchronous clock domain and an 8-bit host data path.
 */
package lta_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int LTA_ADDR_W = 8;
    localparam int LTA_DEC_W = 5;
    localparam int LTA_DATA_W = 8;
    localparam int LTA_NUM_RX = 4;
    localparam int LTA_NUM_TX = 2;

    // ----------------------------------------------------------------
    // Register offsets (upper address bits are not decoded)
    // ----------------------------------------------------------------
    localparam logic [LTA_DEC_W-1:0] LTA_OFF_IDENT = 5'h00;
    localparam logic [LTA_DEC_W-1:0] LTA_OFF_ANALOG_LOOP = 5'h01;
    localparam logic [LTA_DEC_W-1:0] LTA_OFF_REMOTE_LOOP = 5'h02;
    localparam logic [LTA_DEC_W-1:0] LTA_OFF_ALL_ONES = 5'h03;
    localparam logic [LTA_DEC_W-1:0] LTA_OFF_LOSS_STATUS = 5'h04;
    localparam logic [LTA_DEC_W-1:0] LTA_OFF_SHORT_STATUS = 5'h05;
    localparam logic [LTA_DEC_W-1:0] LTA_OFF_LOSS_IRQ_EN = 5'h06;
    localparam logic [LTA_DEC_W-1:0] LTA_OFF_SHORT_IRQ_EN = 5'h07;
    localparam logic [LTA_DEC_W-1:0] LTA_OFF_LOSS_CHANGE = 5'h08;
    localparam logic [LTA_DEC_W-1:0] LTA_OFF_SHORT_CHANGE = 5'h09;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [LTA_NUM_TX-1:0] LTA_RST_TX = 2'h0;
    localparam logic [LTA_NUM_RX-1:0] LTA_RST_RX = 4'h0;
    localparam logic [LTA_DATA_W-1:0] LTA_RST_DATA = 8'h00;

    // Arbitrary neutral identity value
    localparam logic [LTA_DATA_W-1:0] LTA_IDENT_VALUE = 8'h5A;

endpackage

// file: rtl/lta_regs.sv
/*
 * Host control and status register bank of a dual-channel line transceiver:
 * loopback and all-ones controls, loss-of-signal and driver-short status,
 * change latches, enables and the interrupt request.
 * Assumes a synchronous host port on the same clock; line monitors and
 * mode straps are asynchronous and are synchronised here.
 */
// Summary of operation
// [RQ1] Analog loopback enable per transceiver, bits 1-0
// [RQ2] Remote loopback enable per transceiver, bits 1-0
// [RQ3] Host writes zero to unused upper bits
// [RQ4] All-ones enable forces marks on line output
// [RQ5] All-ones and loss status clear at reset
// [RQ6] Loss status bit follows valid loss detection
// [RQ7] Any loss status change raises interrupt event
// [RQ8] One read clears all loss interrupts
// [RQ9] Driver-short status follows short monitor detection
// [RQ10] Short detection only in T1 3.3V mode
// [RQ11] Short status resets zero; read clears interrupts
// [RQ12] All-ones timed by master, else transmit clock
// [RQ13] No all-ones when both clocks held high
// [RQ14] Loss interrupt enable per receiver, bits 3-0
// [RQ15] Loss interrupt enables clear at reset
// [RQ16] Change flag latches on loss status change
// [RQ17] Driver-short interrupt enable per transceiver
// [RQ18] Interrupt while enabled change flag is set
// [RQ19] Unused upper bits read as zero
module lta_regs
    import lta_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Host register port
    input wire logic [LTA_ADDR_W-1:0] host_addr,
    input wire logic host_write,
    input wire logic host_read,
    input wire logic [LTA_DATA_W-1:0] host_wdata,
    output logic [LTA_DATA_W-1:0] host_rdata,
    output logic host_rvalid,
    // Line monitors, asynchronous
    input wire logic [LTA_NUM_RX-1:0] signal_loss_detect,
    input wire logic [LTA_NUM_TX-1:0] driver_short_detect,
    // Mode and clock status, asynchronous
    input wire logic t1_mode,
    input wire logic transmit_supply_3v3,
    input wire logic master_clock_present,
    input wire logic master_clock_high,
    input wire logic [LTA_NUM_TX-1:0] channel_transmit_clock_high,
    // Transceiver controls
    output logic [LTA_NUM_TX-1:0] analog_loop_enable,
    output logic [LTA_NUM_TX-1:0] remote_loop_enable,
    output logic [LTA_NUM_TX-1:0] all_ones_transmit,
    output logic [LTA_NUM_TX-1:0] all_ones_ref_transmit_clock,
    // Interrupt request, active high
    output logic irq
);

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic logic hits(input logic [LTA_ADDR_W-1:0] addr, input logic [LTA_DEC_W-1:0] off);
        hits = (addr[LTA_DEC_W-1:0] == off);
    endfunction

    function automatic logic [LTA_DATA_W-1:0] pad_rx(input logic [LTA_NUM_RX-1:0] v);
        pad_rx = {{(LTA_DATA_W-LTA_NUM_RX){1'b0}}, v};
    endfunction

    function automatic logic [LTA_DATA_W-1:0] pad_tx(input logic [LTA_NUM_TX-1:0] v);
        pad_tx = {{(LTA_DATA_W-LTA_NUM_TX){1'b0}}, v};
    endfunction

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    localparam int SYNC_W = LTA_NUM_RX + LTA_NUM_TX + 4 + LTA_NUM_TX;
    logic [SYNC_W-1:0] sync_meta;
    logic [SYNC_W-1:0] sync_out;
    logic [SYNC_W-1:0] next_sync_meta;
    logic [SYNC_W-1:0] next_sync_out;

    // Only the second stage is read, so metastability stays inside the pair
    always_comb begin
        next_sync_meta = {signal_loss_detect, driver_short_detect, t1_mode, transmit_supply_3v3,
                          master_clock_present, master_clock_high, channel_transmit_clock_high};
        next_sync_out = sync_meta;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            sync_meta <= '0;
            sync_out <= '0;
        end else begin
            sync_meta <= next_sync_meta;
            sync_out <= next_sync_out;
        end
    end

    logic [LTA_NUM_RX-1:0] loss_in;
    logic [LTA_NUM_TX-1:0] short_in;
    logic t1_s;
    logic supply_s;
    logic mclk_present_s;
    logic mclk_high_s;
    logic [LTA_NUM_TX-1:0] channel_transmit_clock_high_s;

    assign {loss_in, short_in, t1_s, supply_s, mclk_present_s, mclk_high_s, channel_transmit_clock_high_s} = sync_out;

    // ----------------------------------------------------------------
    // Loopback controls
    // ----------------------------------------------------------------
    logic [LTA_NUM_TX-1:0] analog_loop;
    logic [LTA_NUM_TX-1:0] remote_loop;
    logic [LTA_NUM_TX-1:0] next_analog_loop;
    logic [LTA_NUM_TX-1:0] next_remote_loop;

    // Upper data bits are simply not stored, so a stray one cannot stick
    always_comb begin
        next_analog_loop = analog_loop;
        next_remote_loop = remote_loop;
        if (host_write && hits(host_addr, LTA_OFF_ANALOG_LOOP)) begin
            next_analog_loop = host_wdata[LTA_NUM_TX-1:0]; // [RQ1]
        end
        if (host_write && hits(host_addr, LTA_OFF_REMOTE_LOOP)) begin
            next_remote_loop = host_wdata[LTA_NUM_TX-1:0]; // [RQ2]
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            analog_loop <= LTA_RST_TX;
            remote_loop <= LTA_RST_TX;
        end else begin
            analog_loop <= next_analog_loop;
            remote_loop <= next_remote_loop;
        end
    end

    // ----------------------------------------------------------------
    // All-ones control
    // ----------------------------------------------------------------
    logic [LTA_NUM_TX-1:0] all_ones_enable;
    logic [LTA_NUM_TX-1:0] next_all_ones_enable;

    always_comb begin
        next_all_ones_enable = all_ones_enable;
        if (host_write && hits(host_addr, LTA_OFF_ALL_ONES)) begin
            next_all_ones_enable = host_wdata[LTA_NUM_TX-1:0]; // [RQ4]
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            all_ones_enable <= LTA_RST_TX; // [RQ5]
        end else begin
            all_ones_enable <= next_all_ones_enable;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt enables
    // ----------------------------------------------------------------
    logic [LTA_NUM_RX-1:0] signal_loss_irq_enable;
    logic [LTA_NUM_TX-1:0] driver_short_irq_enable;
    logic [LTA_NUM_RX-1:0] next_signal_loss_irq_enable;
    logic [LTA_NUM_TX-1:0] next_driver_short_irq_enable;

    always_comb begin
        next_signal_loss_irq_enable = signal_loss_irq_enable;
        next_driver_short_irq_enable = driver_short_irq_enable;
        if (host_write && hits(host_addr, LTA_OFF_LOSS_IRQ_EN)) begin
            next_signal_loss_irq_enable = host_wdata[LTA_NUM_RX-1:0]; // [RQ14]
        end
        if (host_write && hits(host_addr, LTA_OFF_SHORT_IRQ_EN)) begin
            next_driver_short_irq_enable = host_wdata[LTA_NUM_TX-1:0]; // [RQ17]
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            signal_loss_irq_enable <= LTA_RST_RX; // [RQ15]
            driver_short_irq_enable <= LTA_RST_TX;
        end else begin
            signal_loss_irq_enable <= next_signal_loss_irq_enable;
            driver_short_irq_enable <= next_driver_short_irq_enable;
        end
    end

    // ----------------------------------------------------------------
    // Loss-of-signal status and change latches
    // ----------------------------------------------------------------
    logic [LTA_NUM_RX-1:0] signal_loss_flag;
    logic [LTA_NUM_RX-1:0] signal_loss_change_flag;
    logic [LTA_NUM_RX-1:0] next_signal_loss_flag;
    logic [LTA_NUM_RX-1:0] next_signal_loss_change_flag;
    logic clear_loss;

    // Status is live; only the change latches are sticky
    always_comb begin
        next_signal_loss_flag = loss_in; // [RQ6]
        // Reading the loss status or loss change register clears all loss change latches
        clear_loss = host_read
                     & (hits(host_addr, LTA_OFF_LOSS_STATUS) | hits(host_addr, LTA_OFF_LOSS_CHANGE)); // [RQ8]
        // A change in the same cycle as the clear still latches
        next_signal_loss_change_flag = (clear_loss ? LTA_RST_RX : signal_loss_change_flag)
                                       | (next_signal_loss_flag ^ signal_loss_flag); // [RQ7] [RQ16]
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            signal_loss_flag <= LTA_RST_RX; // [RQ5]
            signal_loss_change_flag <= LTA_RST_RX;
        end else begin
            signal_loss_flag <= next_signal_loss_flag;
            signal_loss_change_flag <= next_signal_loss_change_flag;
        end
    end

    // ----------------------------------------------------------------
    // Driver-short status and change latches
    // ----------------------------------------------------------------
    logic [LTA_NUM_TX-1:0] driver_short_flag;
    logic [LTA_NUM_TX-1:0] driver_short_change_flag;
    logic [LTA_NUM_TX-1:0] next_driver_short_flag;
    logic [LTA_NUM_TX-1:0] next_driver_short_change_flag;
    logic short_valid;
    logic clear_short;

    // Outside T1 at 3.3V the monitor means nothing, so status is held at zero
    always_comb begin
        short_valid = t1_s & supply_s; // [RQ10]
        next_driver_short_flag = short_valid ? short_in : LTA_RST_TX; // [RQ9]
        clear_short = host_read
                      & (hits(host_addr, LTA_OFF_SHORT_STATUS) | hits(host_addr, LTA_OFF_SHORT_CHANGE)); // [RQ11]
        next_driver_short_change_flag = (clear_short ? LTA_RST_TX : driver_short_change_flag)
                                        | (next_driver_short_flag ^ driver_short_flag);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            driver_short_flag <= LTA_RST_TX; // [RQ11]
            driver_short_change_flag <= LTA_RST_TX;
        end else begin
            driver_short_flag <= next_driver_short_flag;
            driver_short_change_flag <= next_driver_short_change_flag;
        end
    end

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    logic [LTA_DATA_W-1:0] rdata;
    logic rvalid;
    logic [LTA_DATA_W-1:0] next_rdata;
    logic next_rvalid;

    // Unmapped offsets and unused bits read zero
    always_comb begin
        next_rvalid = host_read;
        next_rdata = LTA_RST_DATA;
        if (host_read) begin
            case (host_addr[LTA_DEC_W-1:0])
                LTA_OFF_IDENT: next_rdata = LTA_IDENT_VALUE;
                LTA_OFF_ANALOG_LOOP: next_rdata = pad_tx(analog_loop); // [RQ19]
                LTA_OFF_REMOTE_LOOP: next_rdata = pad_tx(remote_loop);
                LTA_OFF_ALL_ONES: next_rdata = pad_tx(all_ones_enable);
                LTA_OFF_LOSS_STATUS: next_rdata = pad_rx(signal_loss_flag);
                LTA_OFF_SHORT_STATUS: next_rdata = pad_tx(driver_short_flag);
                LTA_OFF_LOSS_IRQ_EN: next_rdata = pad_rx(signal_loss_irq_enable);
                LTA_OFF_SHORT_IRQ_EN: next_rdata = pad_tx(driver_short_irq_enable);
                LTA_OFF_LOSS_CHANGE: next_rdata = pad_rx(signal_loss_change_flag);
                LTA_OFF_SHORT_CHANGE: next_rdata = pad_tx(driver_short_change_flag);
                default: next_rdata = LTA_RST_DATA;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rdata <= LTA_RST_DATA;
            rvalid <= 1'b0;
        end else begin
            rdata <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

    // ----------------------------------------------------------------
    // Loopback and host outputs
    // ----------------------------------------------------------------
    assign host_rdata = rdata;
    assign host_rvalid = rvalid;
    assign analog_loop_enable = analog_loop;
    assign remote_loop_enable = remote_loop;

    // ----------------------------------------------------------------
    // All-ones outputs
    // ----------------------------------------------------------------
    // Both clocks high means recovery or driver-only mode: no marks there
    always_comb begin
        for (int i = 0; i < LTA_NUM_TX; i++) begin
            all_ones_transmit[i] = all_ones_enable[i] & ~(mclk_high_s & channel_transmit_clock_high_s[i]); // [RQ4] [RQ13]
        end
    end

    // Fall back to the transmit clock only when the master clock is gone
    assign all_ones_ref_transmit_clock = mclk_present_s ? LTA_RST_TX : all_ones_enable; // [RQ12]

    // ----------------------------------------------------------------
    // Interrupt request
    // ----------------------------------------------------------------
    assign irq = (|(signal_loss_change_flag & signal_loss_irq_enable))
                 | (|(driver_short_change_flag & driver_short_irq_enable)); // [RQ18]

endmodule

// file: bench/lta_regs_properties.sv
/* Port assertions for the register bank.
   Assumes binding to lta_regs, one clock, synchronous reset. */
module lta_regs_properties
    import lta_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Host port
    input wire logic [LTA_ADDR_W-1:0] host_addr,
    input wire logic host_write,
    input wire logic host_read,
    input wire logic [LTA_DATA_W-1:0] host_wdata,
    input wire logic [LTA_DATA_W-1:0] host_rdata,
    input wire logic host_rvalid,
    // Line and mode status
    input wire logic [LTA_NUM_RX-1:0] signal_loss_detect,
    input wire logic t1_mode,
    input wire logic master_clock_present,
    input wire logic master_clock_high,
    input wire logic [LTA_NUM_TX-1:0] channel_transmit_clock_high,
    // Controls
    input wire logic [LTA_NUM_TX-1:0] analog_loop_enable,
    input wire logic [LTA_NUM_TX-1:0] remote_loop_enable,
    input wire logic [LTA_NUM_TX-1:0] all_ones_transmit,
    input wire logic [LTA_NUM_TX-1:0] all_ones_ref_transmit_clock,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------
    // Properties
    // ------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    a_analog_loop_write: assert property (
        host_write && host_addr[4:0] == 5'h01 |=> {6'h00, analog_loop_enable} == $past(host_wdata))
        else $error("analog loop bits differ from write");
    a_remote_loop_write: assert property (
        host_write && host_addr[4:0] == 5'h02 |=> {6'h00, remote_loop_enable} == $past(host_wdata))
        else $error("remote loop bits differ from write");
    a_all_ones_write: assert property (
        (!master_clock_high) [*4] ##0 (host_write && host_addr[4:0] == 5'h03)
        |=> {6'h00, all_ones_transmit} == $past(host_wdata))
        else $error("all ones output differs from write");
    a_all_ones_held: assert property (
        (master_clock_high && channel_transmit_clock_high[0]) [*4] |-> !all_ones_transmit[0])
        else $error("all ones sent with both clocks high");
    a_ref_master_used: assert property (
        master_clock_present [*4] |-> all_ones_ref_transmit_clock == 2'h0)
        else $error("transmit clock used while master present");
    a_loss_read_back: assert property (
        $stable(signal_loss_detect) [*5] ##0 (host_read && host_addr[4:0] == 5'h04)
        |=> host_rdata == {4'h0, $past(signal_loss_detect)})
        else $error("loss status differs from detectors");
    a_short_off_mode: assert property (
        (!t1_mode) [*4] ##0 (host_read && host_addr[4:0] == 5'h05) |=> host_rdata == 8'h00)
        else $error("short status outside T1 mode");
    a_upper_bits_zero: assert property (
        host_read && host_addr[4:0] != 5'h00 |=> host_rvalid && host_rdata[7:4] == 4'h0)
        else $error("read answer missing or upper bits set");
    a_reset_cleared: assert property (
        $fell(rst) |-> all_ones_transmit == 2'h0 && remote_loop_enable == 2'h0 && !irq)
        else $error("controls not cleared by reset");
endmodule

bind lta_regs lta_regs_properties u_props (.clock(clock), .rst(rst), .host_addr(host_addr),
    .host_write(host_write), .host_read(host_read), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid), .signal_loss_detect(signal_loss_detect), .t1_mode(t1_mode),
    .master_clock_present(master_clock_present), .master_clock_high(master_clock_high),
    .channel_transmit_clock_high(channel_transmit_clock_high), .analog_loop_enable(analog_loop_enable),
    .remote_loop_enable(remote_loop_enable), .all_ones_transmit(all_ones_transmit),
    .all_ones_ref_transmit_clock(all_ones_ref_transmit_clock), .irq(irq));

// file: bench/lta_host_model.sv
/* Host processor model for the register port.
   Assumes its tasks are called from one bench process. */
module lta_host_model
    import lta_pkg::*;
(
    // Clock
    input wire logic clock,
    // Register port
    output logic [LTA_ADDR_W-1:0] host_addr,
    output logic host_write,
    output logic host_read,
    output logic [LTA_DATA_W-1:0] host_wdata,
    input wire logic [LTA_DATA_W-1:0] host_rdata,
    input wire logic host_rvalid
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        host_addr = 8'h00;
        host_write = 1'b0;
        host_read = 1'b0;
        host_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        #1;
        host_addr = a;
        host_wdata = d & ((a[4:0] == 5'h06) ? 8'h0F : 8'h03);
        host_write = 1'b1;
        @(posedge clock);
        #1;
        host_write = 1'b0;
        // Stale data never lingers on the bus
        host_wdata = ~host_wdata;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        #1;
        host_addr = a;
        host_read = 1'b1;
        @(posedge clock);
        #1;
        host_read = 1'b0;
        d = host_rvalid ? host_rdata : 8'hxx;
    endtask
endmodule

// file: bench/tb_top.sv
/* Self-checking bench for the register bank.
   Assumes the host model and checker are compiled first. */
module tb_top
    import lta_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] host_addr, host_wdata, host_rdata, rv;
    logic host_write, host_read, host_rvalid, irq, t1_mode, transmit_supply_3v3;
    logic master_clock_present, master_clock_high;
    logic [3:0] signal_loss_detect;
    logic [1:0] driver_short_detect, channel_transmit_clock_high;
    logic [1:0] analog_loop_enable, remote_loop_enable, all_ones_transmit, all_ones_ref_transmit_clock;
    int errors = 0;
    int compares = 0;
    int cycles = 0;
    lta_regs dut (.clock(clock), .rst(rst), .host_addr(host_addr), .host_write(host_write),
        .host_read(host_read), .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
        .signal_loss_detect(signal_loss_detect), .driver_short_detect(driver_short_detect),
        .t1_mode(t1_mode), .transmit_supply_3v3(transmit_supply_3v3),
        .master_clock_present(master_clock_present), .master_clock_high(master_clock_high),
        .channel_transmit_clock_high(channel_transmit_clock_high), .analog_loop_enable(analog_loop_enable),
        .remote_loop_enable(remote_loop_enable), .all_ones_transmit(all_ones_transmit),
        .all_ones_ref_transmit_clock(all_ones_ref_transmit_clock), .irq(irq));
    lta_host_model host (.clock(clock), .host_addr(host_addr), .host_write(host_write),
        .host_read(host_read), .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rvalid(host_rvalid));
    always #4 clock = ~clock;
    task automatic summarize;
        if (errors == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Hang guard, well above the run length
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            summarize();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: saw 0x%h, expected 0x%h", $time, seen, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, rv);
        chk(rv, exp);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // ------------------------------------------------
    // Sequence
    // ------------------------------------------------
    initial begin
        {signal_loss_detect, driver_short_detect, channel_transmit_clock_high} = 8'h00;
        {t1_mode, transmit_supply_3v3, master_clock_present, master_clock_high} = 4'h6;
        idle(8);
        rst = 1'b0;
        rdchk(8'h00, LTA_IDENT_VALUE);
        for (int a = 1; a < 10; a++) begin
            rdchk(a[7:0], 8'h00);
        end
        rdchk(8'h1F, 8'h00);
        for (int i = 0; i < 4; i++) begin
            host.wr(8'h01, i[7:0] | 8'hFC);
            host.wr(8'h02, 8'h03 - i[7:0]);
            host.wr(8'h03, i[7:0]);
            chk({6'h00, analog_loop_enable}, i[7:0]);
            chk({6'h00, remote_loop_enable}, 8'h03 - i[7:0]);
            chk({6'h00, all_ones_transmit}, i[7:0]);
            rdchk(8'h21, i[7:0]);
            rdchk(8'h03, i[7:0]);
        end
        chk({6'h00, all_ones_ref_transmit_clock}, 8'h00);
        master_clock_present = 1'b0;
        idle(5);
        chk({6'h00, all_ones_ref_transmit_clock}, 8'h03);
        {master_clock_high, channel_transmit_clock_high} = 3'h5;
        idle(5);
        chk({6'h00, all_ones_transmit}, 8'h02);
        master_clock_high = 1'b0;
        host.wr(8'h06, 8'h05);
        signal_loss_detect = 4'h3;
        idle(5);
        chk({7'h00, irq}, 8'h01);
        rdchk(8'h08, 8'h03);
        chk({7'h00, irq}, 8'h00);
        signal_loss_detect = 4'h2;
        idle(5);
        chk({7'h00, irq}, 8'h01);
        host.wr(8'h06, 8'h04);
        chk({7'h00, irq}, 8'h00);
        host.wr(8'h06, 8'h01);
        rdchk(8'h06, 8'h01);
        rdchk(8'h04, 8'h02);
        chk({7'h00, irq}, 8'h00);
        t1_mode = 1'b1;
        driver_short_detect = 2'h2;
        host.wr(8'h07, 8'h02);
        idle(3);
        chk({7'h00, irq}, 8'h01);
        rdchk(8'h05, 8'h02);
        chk({7'h00, irq}, 8'h00);
        transmit_supply_3v3 = 1'b0;
        idle(5);
        rdchk(8'h09, 8'h02);
        rdchk(8'h05, 8'h00);
        // Second reset while controls are set must clear them again
        rst = 1'b1;
        idle(2);
        rst = 1'b0;
        chk({6'h00, all_ones_transmit}, 8'h00);
        rdchk(8'h03, 8'h00);
        rdchk(8'h06, 8'h00);
        summarize();
    end
endmodule
